// File: lane_code_error_status.sv
// per-lane 8b/10b receive error status with register port
// assumes one error strobe per lane and type from the lane decoders
`timescale 1ns/1ps
`default_nettype none
module lane_code_error_status (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  disp_err,
  input  wire logic [7:0]  miss_err,
  input  wire logic [7:0]  stray_err,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata
);
  logic [7:0] lane_error_threshold_q;
  logic [2:0] clr_q;
  logic [7:0] lane_disparity_fault_bit_q;
  logic [7:0] lane_lookup_miss_bit_q;
  logic [7:0] lane_stray_control_bit_q;
  logic [7:0] lane_disparity_fault_bit_d;
  logic [7:0] lane_lookup_miss_bit_d;
  logic [7:0] lane_stray_control_bit_d;
  logic [7:0] reg_rdata_q;
  logic [7:0] reg_rdata_d;
  logic [7:0] disp_cnt  [8];
  logic [7:0] miss_cnt  [8];
  logic [7:0] stray_cnt [8];

  // threshold register, software writable
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      lane_error_threshold_q <= lane_err_pkg::THRESHOLD_RST;
    else if (reg_wr && reg_addr == lane_err_pkg::THRESHOLD_OFF)
      lane_error_threshold_q <= reg_wdata;
  end

  // counter clear strobes, self clearing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      clr_q <= 3'h0;
    else if (reg_wr && reg_addr == lane_err_pkg::COUNT_CLR_OFF)
      clr_q <= reg_wdata[2:0];
    else
      clr_q <= 3'h0;
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_lane
    lane_err_counter u_disp (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .err_pulse (disp_err[i]),
      .clr       (clr_q[lane_err_pkg::CLR_DISP_BIT]),
      .count     (disp_cnt[i])
    );
    lane_err_counter u_miss (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .err_pulse (miss_err[i]),
      .clr       (clr_q[lane_err_pkg::CLR_MISS_BIT]),
      .count     (miss_cnt[i])
    );
    lane_err_counter u_stray (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .err_pulse (stray_err[i]),
      .clr       (clr_q[lane_err_pkg::CLR_STRAY_BIT]),
      .count     (stray_cnt[i])
    );
    assign lane_disparity_fault_bit_d[i] = disp_cnt[i] >= lane_error_threshold_q;
    assign lane_lookup_miss_bit_d[i]     = miss_cnt[i] >= lane_error_threshold_q;
    assign lane_stray_control_bit_d[i]   = stray_cnt[i] >= lane_error_threshold_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      lane_disparity_fault_bit_q <= lane_err_pkg::STATUS_RST;
      lane_lookup_miss_bit_q     <= lane_err_pkg::STATUS_RST;
      lane_stray_control_bit_q   <= lane_err_pkg::STATUS_RST;
    end
    else
    begin
      lane_disparity_fault_bit_q <= lane_disparity_fault_bit_d;
      lane_lookup_miss_bit_q     <= lane_lookup_miss_bit_d;
      lane_stray_control_bit_q   <= lane_stray_control_bit_d;
    end
  end

  always_comb
  begin
    reg_rdata_d = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        lane_err_pkg::DISPARITY_OFF:   reg_rdata_d = lane_disparity_fault_bit_q;
        lane_err_pkg::LOOKUP_MISS_OFF: reg_rdata_d = lane_lookup_miss_bit_q;
        lane_err_pkg::STRAY_CTRL_OFF:  reg_rdata_d = lane_stray_control_bit_q;
        lane_err_pkg::THRESHOLD_OFF:   reg_rdata_d = lane_error_threshold_q;
        default:                       reg_rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata_q <= lane_err_pkg::STATUS_RST;
    else
      reg_rdata_q <= reg_rdata_d;
  end

  assign reg_rdata = reg_rdata_q;

  AST_DISP_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 lane_disparity_fault_bit_q[0] == ($past(disp_cnt[0]) >= $past(lane_error_threshold_q)))
    else $error("lane 0 disparity status mismatch");
  AST_MISS_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 lane_lookup_miss_bit_q[7] == ($past(miss_cnt[7]) >= $past(lane_error_threshold_q)))
    else $error("lane 7 lookup miss status mismatch");
  AST_STRAY_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 lane_stray_control_bit_q[3] == ($past(stray_cnt[3]) >= $past(lane_error_threshold_q)))
    else $error("lane 3 stray control status mismatch");
  AST_BELOW_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (disp_cnt[2] < lane_error_threshold_q && !clr_q[0]) ##1 (disp_cnt[2] < lane_error_threshold_q)
    |-> !lane_disparity_fault_bit_q[2])
    else $error("status set below threshold");
  AST_RESET_ZERO: assert property (@(posedge sys_clk)
    !rst_n |=> (lane_stray_control_bit_q == 8'h00 && lane_lookup_miss_bit_q == 8'h00))
    else $error("status not zero after reset");
  AST_READ_DISP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == lane_err_pkg::DISPARITY_OFF)
    |=> reg_rdata == $past(lane_disparity_fault_bit_q))
    else $error("disparity read wrong");
  AST_READ_RO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == lane_err_pkg::LOOKUP_MISS_OFF) |=> $stable(lane_error_threshold_q))
    else $error("status write disturbed threshold");
  AST_SHARED_THR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (disp_cnt[5] == miss_cnt[5]) |=> lane_disparity_fault_bit_q[5] == lane_lookup_miss_bit_q[5])
    else $error("threshold not shared");

  // read port checks
  AST_READ_MISS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == lane_err_pkg::LOOKUP_MISS_OFF)
    |=> reg_rdata == $past(lane_lookup_miss_bit_q))
    else $error("lookup miss read wrong");

  AST_READ_STRAY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == lane_err_pkg::STRAY_CTRL_OFF)
    |=> reg_rdata == $past(lane_stray_control_bit_q))
    else $error("stray control read wrong");

  AST_READ_THR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == lane_err_pkg::THRESHOLD_OFF)
    |=> reg_rdata == $past(lane_error_threshold_q))
    else $error("threshold read wrong");

  AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data left standing");

  AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == lane_err_pkg::COUNT_CLR_OFF)
    |=> reg_rdata == 8'h00)
    else $error("clear register read not zero");

  // status checks
  AST_THR_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lane_error_threshold_q == 8'h00
    |=> (lane_disparity_fault_bit_q & lane_lookup_miss_bit_q & lane_stray_control_bit_q) == 8'hFF)
    else $error("zero threshold left a bit clear");

  AST_ABOVE_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (disp_cnt[6] >= lane_error_threshold_q) |=> lane_disparity_fault_bit_q[6])
    else $error("lane 6 disparity status not set");

  AST_MISS_ABOVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (miss_cnt[7] >= lane_error_threshold_q) |=> lane_lookup_miss_bit_q[7])
    else $error("lane 7 lookup miss status not set");

  AST_STRAY_ABOVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stray_cnt[3] >= lane_error_threshold_q) |=> lane_stray_control_bit_q[3])
    else $error("lane 3 stray control status not set");

  AST_LOW_MISS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (miss_cnt[1] < lane_error_threshold_q) |=> !lane_lookup_miss_bit_q[1])
    else $error("lane 1 lookup miss set below threshold");

  AST_LOW_STRAY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stray_cnt[0] < lane_error_threshold_q) |=> !lane_stray_control_bit_q[0])
    else $error("lane 0 stray control set below threshold");

  // reset and control checks
  AST_RESET_DISP: assert property (@(posedge sys_clk)
    !rst_n
    |=> (lane_disparity_fault_bit_q == 8'h00 && reg_rdata == 8'h00))
    else $error("disparity status or read data not zero after reset");

  AST_THR_RESET: assert property (@(posedge sys_clk)
    !rst_n
    |=> lane_error_threshold_q == lane_err_pkg::THRESHOLD_RST)
    else $error("threshold wrong after reset");

  AST_CLR_SELF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clr_q != 3'h0 && !(reg_wr && reg_addr == lane_err_pkg::COUNT_CLR_OFF))
    |=> clr_q == 3'h0)
    else $error("clear strobe not self clearing");

  AST_CLEARED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_q[lane_err_pkg::CLR_MISS_BIT]
    |=> miss_cnt[0] == lane_err_pkg::CNT_RST)
    else $error("lookup miss counter not cleared");

  AST_RO_DISP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == lane_err_pkg::DISPARITY_OFF)
    |=> ($stable(lane_error_threshold_q) && clr_q == 3'h0))
    else $error("status write had an effect");

  AST_THR_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == lane_err_pkg::THRESHOLD_OFF)
    |=> lane_error_threshold_q == $past(reg_wdata))
    else $error("threshold write lost");
endmodule : lane_code_error_status
`default_nettype wire

// File: lane_err_pkg.sv
// constants for the lane error status block
// assumes a 12-bit register address and 8-bit register data
package lane_err_pkg;
  localparam int unsigned NUM_LANES       = 8;
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CNT_W           = 8;
  localparam logic [11:0] DISPARITY_OFF   = 12'h46D;
  localparam logic [11:0] LOOKUP_MISS_OFF = 12'h46E;
  localparam logic [11:0] STRAY_CTRL_OFF  = 12'h46F;
  localparam logic [11:0] THRESHOLD_OFF   = 12'h46C;
  localparam logic [11:0] COUNT_CLR_OFF   = 12'h46B;
  localparam logic [7:0]  THRESHOLD_RST   = 8'hFF;
  localparam logic [7:0]  STATUS_RST      = 8'h00;
  localparam logic [7:0]  CNT_RST         = 8'h00;
  localparam logic [7:0]  CNT_MAX         = 8'hFF;
  localparam int unsigned CLR_DISP_BIT    = 0;
  localparam int unsigned CLR_MISS_BIT    = 1;
  localparam int unsigned CLR_STRAY_BIT   = 2;
endpackage : lane_err_pkg

// File: lane_err_counter.sv
// one saturating error counter for one lane and one error type
// assumes the error strobe is one cycle per received bad symbol
`timescale 1ns/1ps
`default_nettype none
module lane_err_counter (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       err_pulse,
  input  wire logic       clr,
  output logic [7:0]      count
);
  logic [7:0] count_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clr)
      count_q <= lane_err_pkg::CNT_RST;
    else if (err_pulse && count_q != lane_err_pkg::CNT_MAX)
      count_q <= count_q + 8'h01;
  end

  assign count = count_q;

  AST_SATURATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($past(rst_n) && $past(count_q) == lane_err_pkg::CNT_MAX && !$past(clr))
    |-> count_q == lane_err_pkg::CNT_MAX)
    else $error("counter left saturation");
endmodule : lane_err_counter
`default_nettype wire

// File: lane_err_source.sv
// lane transmitter model raising per-lane error strobes
// assumes sys_clk from the bench; strobes idle low
`timescale 1ns/1ps
`default_nettype none
module lane_err_source (
  input  wire logic  sys_clk,
  output logic [7:0] disp_err,
  output logic [7:0] miss_err,
  output logic [7:0] stray_err
);
  initial
  begin
    disp_err = 8'h00;
    miss_err = 8'h00;
    stray_err = 8'h00;
  end
  // n one-cycle strobes on the lanes in mask, kind 0 disp, 1 miss, 2 stray
  task automatic burst(input int kind, input logic [7:0] mask, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      disp_err <= (kind == 0) ? mask : 8'h00;
      miss_err <= (kind == 1) ? mask : 8'h00;
      stray_err <= (kind == 2) ? mask : 8'h00;
    end
    @(posedge sys_clk);
    {disp_err, miss_err, stray_err} <= 24'h000000;
  endtask : burst
endmodule : lane_err_source
`default_nettype wire

// File: lane_code_error_status_test.sv
// self-checking bench for the lane error status block
// assumes the lane_err_source model on the error strobes
`timescale 1ns/1ps
`default_nettype none
module lane_code_error_status_test;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [7:0]  disp_err, miss_err, stray_err;
  int          miscompares = 0;
  int          samples_checked = 0;
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  lane_code_error_status dut (.sys_clk(sys_clk), .rst_n(rst_n), .disp_err(disp_err),
    .miss_err(miss_err), .stray_err(stray_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  lane_err_source src (.sys_clk(sys_clk), .disp_err(disp_err), .miss_err(miss_err),
    .stray_err(stray_err));
  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : cmp
  task automatic rd(input string name, input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    cmp(name, exp, reg_rdata);
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge sys_clk);
  endtask : settle
  task automatic t_reset();
    rd("disp", lane_err_pkg::DISPARITY_OFF, 8'h00);
    rd("miss", lane_err_pkg::LOOKUP_MISS_OFF, 8'h00);
    rd("stray", lane_err_pkg::STRAY_CTRL_OFF, 8'h00);
  endtask : t_reset
  task automatic t_threshold();
    wr(lane_err_pkg::THRESHOLD_OFF, 8'h03);
    src.burst(0, 8'h81, 2);
    settle();
    rd("disp below", lane_err_pkg::DISPARITY_OFF, 8'h00);
    src.burst(0, 8'h01, 1);
    settle();
    rd("disp at", lane_err_pkg::DISPARITY_OFF, 8'h01);
  endtask : t_threshold
  task automatic t_types();
    src.burst(1, 8'h80, 3);
    src.burst(2, 8'h08, 4);
    settle();
    rd("miss", lane_err_pkg::LOOKUP_MISS_OFF, 8'h80);
    rd("stray", lane_err_pkg::STRAY_CTRL_OFF, 8'h08);
    rd("disp", 12'h46D, 8'h01);
  endtask : t_types
  task automatic t_readonly();
    wr(lane_err_pkg::DISPARITY_OFF, 8'hFF);
    rd("disp ro", lane_err_pkg::DISPARITY_OFF, 8'h01);
    rd("unmapped", 12'h3FF, 8'h00);
  endtask : t_readonly
  task automatic t_saturate();
    wr(lane_err_pkg::COUNT_CLR_OFF, 8'h07);
    settle();
    rd("cleared", lane_err_pkg::DISPARITY_OFF, 8'h00);
    src.burst(0, 8'hFF, 260);
    wr(lane_err_pkg::THRESHOLD_OFF, 8'hFF);
    settle();
    rd("saturated", lane_err_pkg::DISPARITY_OFF, 8'hFF);
  endtask : t_saturate
  task automatic t_control();
    rd("thr read", lane_err_pkg::THRESHOLD_OFF, 8'hFF);
    @(posedge sys_clk);
    #1;
    cmp("rdata idle", 8'h00, reg_rdata);
    rd("clear read", lane_err_pkg::COUNT_CLR_OFF, 8'h00);
    wr(lane_err_pkg::THRESHOLD_OFF, 8'h00);
    settle();
    rd("miss thr0", lane_err_pkg::LOOKUP_MISS_OFF, 8'hFF);
    rd("stray thr0", lane_err_pkg::STRAY_CTRL_OFF, 8'hFF);
    src.burst(1, 8'h0F, 1);
    src.burst(2, 8'hF0, 1);
    wr(lane_err_pkg::THRESHOLD_OFF, 8'h01);
    settle();
    rd("miss one", lane_err_pkg::LOOKUP_MISS_OFF, 8'h0F);
    wr(lane_err_pkg::COUNT_CLR_OFF, 8'h02);
    settle();
    rd("miss cleared", lane_err_pkg::LOOKUP_MISS_OFF, 8'h00);
    rd("stray kept", lane_err_pkg::STRAY_CTRL_OFF, 8'hF0);
    rd("disp kept", lane_err_pkg::DISPARITY_OFF, 8'hFF);
  endtask : t_control
  task automatic t_rereset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd("thr after reset", lane_err_pkg::THRESHOLD_OFF, lane_err_pkg::THRESHOLD_RST);
    rd("disp after reset", lane_err_pkg::DISPARITY_OFF, lane_err_pkg::STATUS_RST);
    rd("stray after reset", lane_err_pkg::STRAY_CTRL_OFF, lane_err_pkg::STATUS_RST);
  endtask : t_rereset
  initial
  begin
    #50000;
    miscompares++;
    test_done();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_threshold();
    t_types();
    t_readonly();
    t_saturate();
    t_control();
    t_rereset();
    test_done();
  end
endmodule : lane_code_error_status_test
`default_nettype wire
